// ===== dofs_pkg.sv
`default_nettype none
package dofs_pkg;

   // Clock and index pulse hold time.
   localparam int CLK_HZ           = 25_000_000;
   localparam int IDX_HOLD_MS      = 10;
   // A longest time, so the cycle count rounds down.
   localparam int IDX_HOLD_CYC_DEF = (IDX_HOLD_MS * CLK_HZ) / 1000;
   localparam int IDX_W            = 18;

   localparam int SEL_W    = 6;
   localparam int NUM_TERM = 4;
   localparam int SRC_N    = 64;

   // Terminal positions in the terminal vector.
   localparam int T_RELAY1 = 0;
   localparam int T_RELAY2 = 1;
   localparam int T_COLL   = 2;
   localparam int T_FAST   = 3;

   // Register byte offsets.
   localparam logic [7:0] OFS_SEL_RELAY1 = 8'h00;
   localparam logic [7:0] OFS_SEL_RELAY2 = 8'h04;
   localparam logic [7:0] OFS_SEL_COLL   = 8'h08;
   localparam logic [7:0] OFS_SEL_FAST   = 8'h0C;
   localparam logic [7:0] OFS_CFG        = 8'h10;
   localparam logic [7:0] OFS_VIRT       = 8'h14;
   localparam logic [7:0] OFS_STAT       = 8'h18;

   // Field positions.
   localparam int CFG_FAST_TYPE_BIT = 0;
   localparam int CFG_CARD_EN_BIT   = 1;
   localparam int VIRT_MODBUS_BIT   = 0;
   localparam int VIRT_FIELD_BIT    = 1;
   localparam int VIRT_ETH_BIT      = 2;
   localparam int VIRT_IETH_BIT     = 3;
   localparam int STAT_IDX_BIT      = 4;

   // Values after reset, and the two fast terminal type codes.
   localparam logic [SEL_W-1:0] SEL_RELAY1_RST = 6'h01;
   localparam logic [SEL_W-1:0] SEL_RELAY2_RST = 6'h05;
   localparam logic [SEL_W-1:0] SEL_COLL_RST   = 6'h00;
   localparam logic [SEL_W-1:0] SEL_FAST_RST   = 6'h00;
   localparam logic             FAST_PULSE     = 1'h0;
   localparam logic             FAST_ONOFF     = 1'h1;
   localparam logic             CARD_EN_RST    = 1'h0;
   localparam logic [3:0]       VIRT_RST       = 4'h0;

   // Selection codes.
   localparam logic [SEL_W-1:0] C_NONE    = 6'h00;
   localparam logic [SEL_W-1:0] C_RUN     = 6'h01;
   localparam logic [SEL_W-1:0] C_FWD     = 6'h02;
   localparam logic [SEL_W-1:0] C_REV     = 6'h03;
   localparam logic [SEL_W-1:0] C_JOG     = 6'h04;
   localparam logic [SEL_W-1:0] C_FAULT   = 6'h05;
   localparam logic [SEL_W-1:0] C_LVL1    = 6'h06;
   localparam logic [SEL_W-1:0] C_LVL2    = 6'h07;
   localparam logic [SEL_W-1:0] C_REACH   = 6'h08;
   localparam logic [SEL_W-1:0] C_ZERO    = 6'h09;
   localparam logic [SEL_W-1:0] C_UPLIM   = 6'h0A;
   localparam logic [SEL_W-1:0] C_LOLIM   = 6'h0B;
   localparam logic [SEL_W-1:0] C_READY   = 6'h0C;
   localparam logic [SEL_W-1:0] C_PREEXC  = 6'h0D;
   localparam logic [SEL_W-1:0] C_OVLD    = 6'h0E;
   localparam logic [SEL_W-1:0] C_UNLD    = 6'h0F;
   localparam logic [SEL_W-1:0] C_STAGE   = 6'h10;
   localparam logic [SEL_W-1:0] C_CYCLE   = 6'h11;
   localparam logic [SEL_W-1:0] C_SETCNT  = 6'h12;
   localparam logic [SEL_W-1:0] C_DESCNT  = 6'h13;
   localparam logic [SEL_W-1:0] C_EXTFLT  = 6'h14;
   localparam logic [SEL_W-1:0] C_RUNTIME = 6'h16;
   localparam logic [SEL_W-1:0] C_VMOD    = 6'h17;
   localparam logic [SEL_W-1:0] C_VFIELD  = 6'h18;
   localparam logic [SEL_W-1:0] C_VETH    = 6'h19;
   localparam logic [SEL_W-1:0] C_DCBUS   = 6'h1A;
   localparam logic [SEL_W-1:0] C_INDEX   = 6'h1B;
   localparam logic [SEL_W-1:0] C_PSUP    = 6'h1C;
   localparam logic [SEL_W-1:0] C_STO     = 6'h1D;
   localparam logic [SEL_W-1:0] C_POSDONE = 6'h1E;
   localparam logic [SEL_W-1:0] C_SPZERO  = 6'h1F;
   localparam logic [SEL_W-1:0] C_SPDIV   = 6'h20;
   localparam logic [SEL_W-1:0] C_SPDLIM  = 6'h21;
   localparam logic [SEL_W-1:0] C_VIETH   = 6'h22;
   localparam logic [SEL_W-1:0] C_MODESW  = 6'h24;
   localparam logic [SEL_W-1:0] C_CARD0   = 6'h29;

endpackage : dofs_pkg
`default_nettype wire

// ===== dofs_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dofs_top
   import dofs_pkg::*;
#(
   parameter int INDEX_HOLD_CYC = IDX_HOLD_CYC_DEF // Index output hold in cycles.
) (
   input  wire logic        core_clk,                 // Control clock.
   input  wire logic        srst,                     // Synchronous reset.
   input  wire logic [7:0]  paddr,                    // APB address.
   input  wire logic        psel,                     // APB select.
   input  wire logic        penable,                  // APB enable.
   input  wire logic        pwrite,                   // APB direction.
   input  wire logic [31:0] pwdata,                   // APB write data.
   output logic      [31:0] prdata,                   // APB read data.
   output logic             pready,                   // APB ready.
   output logic             pslverr,                  // APB error.
   input  wire logic        running,                  // Drive running.
   input  wire logic        running_fwd,              // Forward running.
   input  wire logic        running_rev,              // Reverse running.
   input  wire logic        jogging,                  // Jogging.
   input  wire logic        freq_output_on,           // Frequency being output.
   input  wire logic        drive_fault,              // Drive fault.
   input  wire logic        freq_level_detect_one,    // First level flag.
   input  wire logic        freq_level_detect_two,    // Second level flag.
   input  wire logic        freq_reached,             // Frequency reached.
   input  wire logic        out_freq_zero,            // Output frequency zero.
   input  wire logic        ref_freq_zero,            // Reference frequency zero.
   input  wire logic        upper_limit_hit,          // At upper limit.
   input  wire logic        lower_limit_hit,          // At lower limit.
   input  wire logic        main_power_ok,            // Main power established.
   input  wire logic        ctrl_power_ok,            // Control power established.
   input  wire logic        protect_active,           // Protection acting.
   input  wire logic        drive_ready,              // Ready to run.
   input  wire logic        pre_exciting,             // Pre-excitation.
   input  wire logic        overload_alarm,           // Overload pre-alarm.
   input  wire logic        underload_alarm,          // Underload pre-alarm.
   input  wire logic        seq_stage_done,           // Sequencer stage done.
   input  wire logic        seq_cycle_done,           // Sequencer cycle done.
   input  wire logic        set_count_hit,            // Set count reached.
   input  wire logic        des_count_hit,            // Designated count reached.
   input  wire logic        ext_fault,                // External fault.
   input  wire logic        run_time_hit,             // Running time reached.
   input  wire logic        bus_above_uv,             // Bus above undervoltage.
   input  wire logic        index_pulse,              // Encoder index pulse.
   input  wire logic        pulse_superpose,          // Pulse superposition.
   input  wire logic        sto_fault,                // Safe torque off fault.
   input  wire logic        position_done,            // Positioning complete.
   input  wire logic        spindle_zero_done,        // Spindle zeroing done.
   input  wire logic        spindle_div_done,         // Scale division done.
   input  wire logic        speed_limited,            // Frequency limited.
   input  wire logic        mode_switch_done,         // Mode switch-over done.
   input  wire logic        card_collector_out_one,   // Card output.
   input  wire logic        card_collector_out_two,   // Card output.
   input  wire logic        card_fast_out,            // Card output.
   input  wire logic        card_relay_out_one,       // Card output.
   input  wire logic        card_relay_out_two,       // Card output.
   input  wire logic        card_relay_out_three,     // Card output.
   input  wire logic        card_relay_out_four,      // Card output.
   input  wire logic        fast_pulse_src,           // Pulse train for pulse mode.
   output logic             relay_output_one,         // Relay terminal one.
   output logic             relay_output_two,         // Relay terminal two.
   output logic             collector_output,         // Open-collector terminal.
   output logic             fast_pulse_output         // Fast terminal.
);

   logic [SEL_W-1:0]    sel_q [NUM_TERM];
   logic                fast_type_q;
   logic                card_enable_setting_q;
   logic [3:0]          virt_q;
   logic [IDX_W-1:0]    idx_cnt_q;
   logic                idx_active_q;
   logic [SRC_N-1:0]    src_vec;
   logic [NUM_TERM-1:0] term_d;
   logic [NUM_TERM-1:0] term_q;
   logic                fast_q;
   logic [31:0]         rdata_d;
   logic                addr_ok;
   logic                acc;
   logic                wr_fire;
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   logic [6:0]          card_vec;

   // The slave inserts one wait state so read data can be registered.
   assign acc     = psel && penable;
   assign wr_fire = acc && pready_q && pwrite && addr_ok;

   always_comb begin
      addr_ok = 1'b1;
      rdata_d = 32'h0000_0000;
      case (paddr)
         OFS_SEL_RELAY1: rdata_d[SEL_W-1:0] = sel_q[T_RELAY1];
         OFS_SEL_RELAY2: rdata_d[SEL_W-1:0] = sel_q[T_RELAY2];
         OFS_SEL_COLL:   rdata_d[SEL_W-1:0] = sel_q[T_COLL];
         OFS_SEL_FAST:   rdata_d[SEL_W-1:0] = sel_q[T_FAST];
         OFS_CFG: begin
            rdata_d[CFG_FAST_TYPE_BIT] = fast_type_q;
            rdata_d[CFG_CARD_EN_BIT]   = card_enable_setting_q;
         end
         OFS_VIRT:       rdata_d[3:0] = virt_q;
         OFS_STAT: begin
            rdata_d[NUM_TERM-1:0]      = {fast_q, term_q[T_COLL:T_RELAY1]};
            rdata_d[STAT_IDX_BIT]      = idx_active_q;
         end
         default:        addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (acc && !pready_q) begin
         pready_q  <= 1'b1;
         prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr_q <= !addr_ok;
      end else begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Each terminal keeps its own six-bit code; the status word is read-only.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sel_q[T_RELAY1] <= SEL_RELAY1_RST;
         sel_q[T_RELAY2] <= SEL_RELAY2_RST;
         sel_q[T_COLL]   <= SEL_COLL_RST;
         sel_q[T_FAST]   <= SEL_FAST_RST;
      end else if (wr_fire) begin
         case (paddr)
            OFS_SEL_RELAY1: sel_q[T_RELAY1] <= pwdata[SEL_W-1:0];
            OFS_SEL_RELAY2: sel_q[T_RELAY2] <= pwdata[SEL_W-1:0];
            OFS_SEL_COLL:   sel_q[T_COLL]   <= pwdata[SEL_W-1:0];
            OFS_SEL_FAST:   sel_q[T_FAST]   <= pwdata[SEL_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fast_type_q           <= FAST_PULSE;
         card_enable_setting_q <= CARD_EN_RST;
      end else if (wr_fire && paddr == OFS_CFG) begin
         fast_type_q           <= pwdata[CFG_FAST_TYPE_BIT];
         card_enable_setting_q <= pwdata[CFG_CARD_EN_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         virt_q <= VIRT_RST;
      end else if (wr_fire && paddr == OFS_VIRT) begin
         virt_q <= pwdata[3:0];
      end
   end

   // A new index pulse reloads the timer, so closely spaced pulses stretch the output.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         idx_cnt_q    <= '0;
         idx_active_q <= 1'b0;
      end else if (index_pulse) begin
         idx_cnt_q    <= IDX_W'(INDEX_HOLD_CYC);
         idx_active_q <= 1'b1;
      end else if (idx_cnt_q > IDX_W'(1)) begin
         idx_cnt_q    <= idx_cnt_q - IDX_W'(1);
      end else begin
         idx_cnt_q    <= '0;
         idx_active_q <= 1'b0;
      end
   end

   assign card_vec = {card_relay_out_four, card_relay_out_three, card_relay_out_two,
                      card_relay_out_one, card_fast_out, card_collector_out_two,
                      card_collector_out_one};

   // Unlisted entries stay zero, so reserved codes read as no function.
   always_comb begin
      src_vec            = '0;
      src_vec[C_RUN]     = running && freq_output_on;
      src_vec[C_FWD]     = running_fwd && freq_output_on;
      src_vec[C_REV]     = running_rev && freq_output_on;
      src_vec[C_JOG]     = jogging && freq_output_on;
      src_vec[C_FAULT]   = drive_fault;
      src_vec[C_LVL1]    = freq_level_detect_one;
      src_vec[C_LVL2]    = freq_level_detect_two;
      src_vec[C_REACH]   = freq_reached;
      src_vec[C_ZERO]    = out_freq_zero && ref_freq_zero;
      src_vec[C_UPLIM]   = upper_limit_hit;
      src_vec[C_LOLIM]   = lower_limit_hit;
      src_vec[C_READY]   = main_power_ok && ctrl_power_ok &&
                           !protect_active && drive_ready;
      src_vec[C_PREEXC]  = pre_exciting;
      src_vec[C_OVLD]    = overload_alarm;
      src_vec[C_UNLD]    = underload_alarm;
      src_vec[C_STAGE]   = seq_stage_done;
      src_vec[C_CYCLE]   = seq_cycle_done;
      src_vec[C_SETCNT]  = set_count_hit;
      src_vec[C_DESCNT]  = des_count_hit;
      src_vec[C_EXTFLT]  = ext_fault;
      src_vec[C_RUNTIME] = run_time_hit;
      src_vec[C_VMOD]    = virt_q[VIRT_MODBUS_BIT];
      src_vec[C_VFIELD]  = virt_q[VIRT_FIELD_BIT];
      src_vec[C_VETH]    = virt_q[VIRT_ETH_BIT];
      src_vec[C_DCBUS]   = bus_above_uv;
      src_vec[C_INDEX]   = idx_active_q;
      src_vec[C_PSUP]    = pulse_superpose;
      src_vec[C_STO]     = sto_fault;
      src_vec[C_POSDONE] = position_done;
      src_vec[C_SPZERO]  = spindle_zero_done;
      src_vec[C_SPDIV]   = spindle_div_done;
      src_vec[C_SPDLIM]  = speed_limited;
      src_vec[C_VIETH]   = virt_q[VIRT_IETH_BIT];
      src_vec[C_MODESW]  = mode_switch_done;
      for (int k = 0; k < 7; k++) begin
         src_vec[int'(C_CARD0) + k] = card_enable_setting_q && card_vec[k];
      end
   end

   // Every terminal indexes the same source vector, so shared codes agree except at the fast terminal in pulse mode.
   always_comb begin
      for (int i = 0; i < NUM_TERM; i++) begin
         term_d[i] = src_vec[sel_q[i]];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         term_q <= '0;
         fast_q <= 1'b0;
      end else begin
         term_q <= term_d;
         // In pulse mode the selected code is ignored and the pulse train is driven.
         fast_q <= (fast_type_q == FAST_PULSE) ? fast_pulse_src : term_d[T_FAST];
      end
   end

   assign relay_output_one  = term_q[T_RELAY1];
   assign relay_output_two  = term_q[T_RELAY2];
   assign collector_output  = term_q[T_COLL];
   assign fast_pulse_output = fast_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence idx_load_s;
      index_pulse ##1 (idx_active_q && idx_cnt_q == IDX_W'(INDEX_HOLD_CYC));
   endsequence

   sequence idx_last_s;
      idx_active_q && idx_cnt_q == IDX_W'(1) && !index_pulse;
   endsequence

   code_zero_a: assert property (sel_q[T_RELAY1] == C_NONE |=> !relay_output_one)
      else $error("Code zero terminal was on.");

   fault_route_a: assert property (sel_q[T_RELAY2] == C_FAULT |=>
      relay_output_two == $past(drive_fault))
      else $error("Fault code did not follow fault.");

   zero_speed_a: assert property (sel_q[T_COLL] == C_ZERO |=>
      collector_output == ($past(out_freq_zero) && $past(ref_freq_zero)))
      else $error("Zero speed code wrong.");

   ready_run_a: assert property (sel_q[T_RELAY1] == C_READY && protect_active
      |=> !relay_output_one)
      else $error("Ready shown while protection acts.");

   card_gate_a: assert property (sel_q[T_RELAY1] inside {[6'h29:6'h2F]} &&
      !card_enable_setting_q |=> !relay_output_one)
      else $error("Card output passed while disabled.");

   reserved_off_a: assert property (
      sel_q[T_RELAY2] inside {6'h15, 6'h23, [6'h25:6'h28], [6'h30:6'h3F]}
      |=> !relay_output_two)
      else $error("Reserved code drove terminal.");

   shared_code_a: assert property (sel_q[T_RELAY1] == sel_q[T_RELAY2]
      |=> relay_output_one == relay_output_two)
      else $error("Terminals with same code differ.");

   pulse_mode_a: assert property (fast_type_q == FAST_PULSE
      |=> fast_pulse_output == $past(fast_pulse_src))
      else $error("Pulse mode not driving pulse train.");

   virt_onoff_a: assert property (fast_type_q == FAST_ONOFF
      && sel_q[T_FAST] == C_VMOD
      |=> fast_pulse_output == $past(virt_q[VIRT_MODBUS_BIT]))
      else $error("Virtual bit not on fast terminal.");

   idx_load_a: assert property (index_pulse |-> idx_load_s)
      else $error("Index timer not reloaded.");

   idx_end_a: assert property (idx_last_s |=> !idx_active_q ##0 idx_cnt_q == '0)
      else $error("Index output did not end.");

   // In on/off mode the fast terminal must match the shared terminal vector bit.
   onoff_mode_a: assert property (fast_type_q == FAST_ONOFF |=>
      fast_pulse_output == term_q[T_FAST])
      else $error("On/off mode fast terminal differs.");

   run_gate_a: assert property (sel_q[T_RELAY1] == C_RUN |=>
      relay_output_one == $past(running && freq_output_on))
      else $error("Run code did not follow running.");

   jog_gate_a: assert property (sel_q[T_COLL] == C_JOG |=>
      collector_output == $past(jogging && freq_output_on))
      else $error("Jog code did not follow jogging.");

   level_one_a: assert property (sel_q[T_RELAY2] == C_LVL1 |=>
      relay_output_two == $past(freq_level_detect_one))
      else $error("Level code did not follow flag.");

   limit_hit_a: assert property (sel_q[T_COLL] == C_UPLIM |=>
      collector_output == $past(upper_limit_hit))
      else $error("Upper limit code wrong.");

   preexc_route_a: assert property (sel_q[T_RELAY1] == C_PREEXC |=>
      relay_output_one == $past(pre_exciting))
      else $error("Pre-excitation code wrong.");

   overload_route_a: assert property (sel_q[T_RELAY2] == C_OVLD |=>
      relay_output_two == $past(overload_alarm))
      else $error("Overload code wrong.");

   seq_cycle_a: assert property (sel_q[T_COLL] == C_CYCLE |=>
      collector_output == $past(seq_cycle_done))
      else $error("Sequencer cycle code wrong.");

   run_time_a: assert property (sel_q[T_RELAY1] == C_RUNTIME |=>
      relay_output_one == $past(run_time_hit))
      else $error("Running time code wrong.");

   ieth_bit_a: assert property (sel_q[T_RELAY2] == C_VIETH |=>
      relay_output_two == $past(virt_q[VIRT_IETH_BIT]))
      else $error("Industrial Ethernet bit code wrong.");

   bus_volt_a: assert property (sel_q[T_COLL] == C_DCBUS |=>
      collector_output == $past(bus_above_uv))
      else $error("Bus voltage code wrong.");

   sto_route_a: assert property (sel_q[T_RELAY1] == C_STO |=>
      relay_output_one == $past(sto_fault))
      else $error("Torque-off code wrong.");

   mode_switch_a: assert property (sel_q[T_RELAY2] == C_MODESW |=>
      relay_output_two == $past(mode_switch_done))
      else $error("Mode switch code wrong.");

   reset_off_a: assert property (disable iff (1'b0) srst |=> !relay_output_one &&
      !relay_output_two && !collector_output && !fast_pulse_output)
      else $error("Terminal on after reset.");

endmodule : dofs_top
`default_nettype wire

// ===== dofs_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module dofs_load_model (
   input  wire logic       clk,    // Control clock.
   input  wire logic [3:0] term,   // Terminal levels, 1 means ON.
   output var  logic [3:0] seen_q  // Load state, one cycle behind.
);
   // A relay contact only follows its coil a cycle later, so the load lags the terminal.
   always_ff @(posedge clk) begin
      seen_q <= term;
   end
endmodule : dofs_load_model
`default_nettype wire

// ===== dofs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
   import dofs_pkg::*;
;
   localparam int HOLD = 20;
   logic            core_clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic            q = 1'h1, pa = 1'h0, fps = 1'h0, pready, pslverr, er, r1, r2, co, fo;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0, prdata, rd;
   logic [63:0]     s = '0;
   logic [3:0]      ld;
   int              error_cnt = 0, total_checks = 0, hi_n = 0, n0;
   int              qc [3] = '{1, 12, 41};
   wire logic [3:0] t = {fo, co, r2, r1};

   dofs_top #(.INDEX_HOLD_CYC(HOLD)) dut_u (
      .core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .running(s[1]), .running_fwd(s[2]), .running_rev(s[3]), .jogging(s[4]),
      .freq_output_on(q), .drive_fault(s[5]), .freq_level_detect_one(s[6]),
      .freq_level_detect_two(s[7]), .freq_reached(s[8]), .out_freq_zero(s[9]),
      .ref_freq_zero(q), .upper_limit_hit(s[10]), .lower_limit_hit(s[11]),
      .main_power_ok(q), .ctrl_power_ok(q), .protect_active(pa), .drive_ready(s[12]),
      .pre_exciting(s[13]), .overload_alarm(s[14]), .underload_alarm(s[15]),
      .seq_stage_done(s[16]), .seq_cycle_done(s[17]), .set_count_hit(s[18]),
      .des_count_hit(s[19]), .ext_fault(s[20]), .run_time_hit(s[22]), .bus_above_uv(s[26]),
      .index_pulse(s[27]), .pulse_superpose(s[28]), .sto_fault(s[29]),
      .position_done(s[30]), .spindle_zero_done(s[31]), .spindle_div_done(s[32]),
      .speed_limited(s[33]), .mode_switch_done(s[36]), .card_collector_out_one(s[41]),
      .card_collector_out_two(s[42]), .card_fast_out(s[43]), .card_relay_out_one(s[44]),
      .card_relay_out_two(s[45]), .card_relay_out_three(s[46]),
      .card_relay_out_four(s[47]), .fast_pulse_src(fps), .relay_output_one(r1),
      .relay_output_two(r2), .collector_output(co), .fast_pulse_output(fo));

   dofs_load_model load_u (.clk(core_clk), .term(t), .seen_q(ld));

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // Counts ON cycles of relay one so one-shot lengths need no sampling alignment.
   always @(posedge core_clk) begin
      hi_n <= hi_n + int'(t[0] === 1'h1);
   end

   task automatic end_sim;
      $display("errors=%0d checks=%0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 16) begin
         error_cnt++;
         end_sim();
      end
   endtask : apb

   task automatic set_all(input int c);
      for (int k = 0; k < NUM_TERM; k++) apb(1'h1, 8'(4 * k), 32'(c));
   endtask : set_all

   task automatic chk_t(input logic [3:0] e);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK(t, e)
      `CHK(ld, t)
      @(posedge core_clk);
   endtask : chk_t

   task automatic chk_regs;
      logic [31:0] ev [6];
      ev = '{32'(SEL_RELAY1_RST), 32'(SEL_RELAY2_RST), 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 6; i++) begin
         apb(1'h0, 8'(4 * i), 32'h0);
         `CHK(rd, ev[i])
      end
      apb(1'h0, 8'h1C, 32'h0);
      `CHK({er, rd}, 33'h100000000)
   endtask : chk_regs

   function automatic logic on_ok(input int c);
      return (c >= 1 && c <= 34 && c != 21) || c == 36 || (c >= 41 && c <= 47);
   endfunction : on_ok

   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'h0;
      chk_regs();
      apb(1'h1, OFS_CFG, 32'h3);
      for (int c = 0; c < SRC_N; c++) begin
         set_all(c);
         apb(1'h1, OFS_VIRT, 32'h0);
         s <= '0;
         chk_t(4'h0);
         apb(1'h1, OFS_VIRT, 32'hF);
         s <= 64'h1 << c;
         chk_t(on_ok(c) ? 4'hF : 4'h0);
      end
      for (int i = 0; i < 3; i++) begin
         apb(1'h1, OFS_CFG, i == 2 ? 32'h1 : 32'h3);
         set_all(qc[i]);
         q <= (i != 0);
         pa <= (i == 1);
         s <= 64'h1 << qc[i];
         chk_t(4'h0);
      end
      pa <= 1'h0;
      s <= '0;
      set_all(C_INDEX);
      for (int g = 0; g < 2; g++) begin
         n0 = hi_n;
         repeat (g + 1) begin
            @(posedge core_clk);
            s[27] <= 1'h1;
            @(posedge core_clk);
            s[27] <= 1'h0;
         end
         repeat (60) @(posedge core_clk);
         `CHK(hi_n - n0, HOLD + 2 * g)
      end
      apb(1'h1, OFS_CFG, 32'h0);
      set_all(C_FAULT);
      s <= 64'h20;
      chk_t(4'h7);
      apb(1'h0, OFS_STAT, 32'h0);
      `CHK(rd, 32'h7)
      fps <= 1'h1;
      chk_t(4'hF);
      apb(1'h1, OFS_SEL_COLL, 32'hFF);
      apb(1'h0, OFS_SEL_COLL, 32'h0);
      `CHK(rd, 32'h3F)
      srst <= 1'h1;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(t, 4'h0)
      @(posedge core_clk);
      srst <= 1'h0;
      chk_regs();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
